// ===== design/setpoint_access_pkg.sv
// Package with constants and types for setpoint access and feature output logic.
`default_nettype none
package setpoint_access_pkg;
  localparam int PASS_CHARS      = 8;
  localparam int CHAR_W          = 8;
  localparam int PASS_W          = PASS_CHARS * CHAR_W;
  // Default passcode is the single character zero, right aligned in the low byte.
  localparam logic [63:0] PASS_DEFAULT = 64'h0000_0000_0000_0030;
  localparam int NUM_PORTS       = 2;
  localparam int NUM_IFS         = NUM_PORTS + 1;
  localparam int KEYPAD_IDX      = 0;
  localparam int CLK_HZ          = 40000000;
  localparam int IDLE_MIN        = 30;
  localparam longint IDLE_CYCLES = longint'(IDLE_MIN) * 60 * CLK_HZ;
  localparam int VAL_W           = 16;
  localparam int DLY_W           = 24;
  localparam int AUX_W           = 5;
  // Register offsets on the software port.
  localparam logic [3:0] REG_PASS_LO  = 4'h0;
  localparam logic [3:0] REG_PASS_HI  = 4'h1;
  localparam logic [3:0] REG_FUNC     = 4'h2;
  localparam logic [3:0] REG_PICKUP   = 4'h3;
  localparam logic [3:0] REG_DELAY    = 4'h4;
  localparam logic [3:0] REG_STATUS   = 4'h5;
  // Field positions in REG_FUNC.
  localparam int F_MODE_LSB  = 0;
  localparam int F_AUX_LSB   = 4;
  localparam int F_DIR_LSB   = 9;
  localparam int F_VOTE_LSB  = 11;
  localparam int F_UNDER_BIT = 13;

  typedef enum logic [2:0]
  {
    MODE_DISABLED      = 3'h0,
    MODE_ENABLED       = 3'h1,
    MODE_TRIP          = 3'h2,
    trip_and_reclose_mode = 3'h3,
    MODE_ALARM         = 3'h4,
    MODE_LATCHED_ALARM = 3'h5,
    MODE_CONTROL       = 3'h6
  } mode_t;
  typedef enum logic [1:0] {DIR_DISABLED = 2'h0, DIR_FORWARD = 2'h1, DIR_REVERSE = 2'h2} dir_t;
  typedef enum logic [1:0] {VOTE_ANY_ONE = 2'h0, VOTE_ANY_TWO = 2'h1, VOTE_ALL_THREE = 2'h2} vote_t;

  // Timer state machine for the delay stage.
  typedef enum logic [1:0] {TMR_IDLE = 2'b01, TMR_RUN = 2'b10} tmr_state_t;

  // Software-written configuration of the feature.
  typedef struct packed
  {
    mode_t              mode;
    logic [AUX_W-1:0]   aux_sel;
    dir_t               dir;
    vote_t              vote;
    logic               under;
    logic [VAL_W-1:0]   pickup;
    logic [DLY_W-1:0]   delay;
  } feat_cfg_t;

  // Outputs of the feature.
  typedef struct packed
  {
    logic             trip;
    logic             alarm;
    logic             relay1;
    logic [AUX_W-1:0] aux;
    logic             reclose_init;
    logic             event_log;
  } feat_out_t;
endpackage : setpoint_access_pkg
`default_nettype wire

// ===== design/setpoint_access.sv
// Setpoint access gating and generic protection feature output logic.
// Notes on behaviour
// - Keypad writes need access terminals connected.
// - Keypad write with terminals open raises error.
// - Terminals never affect serial port writes.
// - Store passcode of up to eight characters.
// - Passcode resets to the character zero.
// - Zero passcode disables passcode restrictions.
// - Nonzero passcode blocks writes until access granted.
// - One access flag per interface, independent.
// - Keypad disable command clears keypad flag.
// - Wrong serial passcode clears that port flag.
// - Thirty idle minutes clear interface flag.
// - Disabled no output; Control drives aux only.
// - Trip mode declares trip, relay 1, aux, message.
// - Trip-and-reclose also pulses reclose initiate.
// - Alarm modes declare alarm, aux relays only.
// - Trip, reclose, non-latched alarm, control outputs are logged.
// - Aux relay mask covers relays three to seven.
// - Element asserts above or below pickup.
// - Fixed programmable delay before feature output.
// - Direction supervision disabled, forward, reverse.
// - Phase voting any one, two, all three.
//
// Chosen here: the strobed register port and the register addresses.
`default_nettype none
module setpoint_access
  import setpoint_access_pkg::*;
#(
  parameter longint IDLE_LIMIT = IDLE_CYCLES
)
(
  input  wire logic                 core_clk_i,
  input  wire logic                 reset_i,
  input  wire logic                 access_jumper_i,
  input  wire logic                 kp_valid_i,
  input  wire logic                 kp_write_i,
  input  wire logic                 kp_enter_pass_i,
  input  wire logic                 kp_disable_i,
  input  wire logic [PASS_W-1:0]    kp_data_i,
  input  wire logic [NUM_IFS-1:0]   wr_en_i,
  input  wire logic [NUM_IFS-1:0]   rd_en_i,
  input  wire logic [3:0]           addr_i [NUM_IFS],
  input  wire logic [31:0]          wdata_i [NUM_IFS],
  input  wire logic                 run_i,
  input  wire logic                 fwd_i,
  input  wire logic                 rev_i,
  input  wire logic [VAL_W-1:0]     meas_i [3],
  output logic [31:0]               rdata_o,
  output logic                      kp_error_o,
  output logic [NUM_IFS-1:0]        access_o,
  output feat_out_t                 feat_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Complete module state in one packed struct.
  typedef struct packed
  {
    logic [1:0]                jump_sync;
    logic [PASS_W-1:0]         pass;
    logic [NUM_IFS-1:0]        granted;
    logic [NUM_IFS-1:0][31:0]  cand_lo;
    logic [NUM_IFS-1:0][42:0]  idle;
    logic                      kp_error;
    logic [31:0]               rdata;
    feat_cfg_t                 cfg;
    tmr_state_t                tmr;
    logic [DLY_W-1:0]          tcnt;
    logic                      active;
    logic                      latched;
    feat_out_t                 fo;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  logic [NUM_IFS-1:0] wr_ok;
  logic [NUM_IFS-1:0] kind;
  logic               pass_zero;
  logic [PASS_W-1:0]  cand;
  logic [1:0]         cnt3;
  logic [2:0]         beyond;
  logic               voted;
  logic               dir_ok;
  logic               elem;
  logic               fire;

  ////////////////////////////////////////////////////////////////////////////
  // Element evaluation and gating terms.
  always_comb
  begin
    pass_zero = (st_r.pass == PASS_DEFAULT);
    for (int i = 0; i < 3; i++)
    begin
      beyond[i] = st_r.cfg.under ? (meas_i[i] < st_r.cfg.pickup)
                                 : (meas_i[i] > st_r.cfg.pickup);
    end
    cnt3 = 2'(beyond[0]) + 2'(beyond[1]) + 2'(beyond[2]);
    case (st_r.cfg.vote)
      VOTE_ANY_ONE:   voted = (cnt3 >= 2'd1);
      VOTE_ANY_TWO:   voted = (cnt3 >= 2'd2);
      VOTE_ALL_THREE: voted = (cnt3 == 2'd3);
      default:        voted = 1'b0;
    endcase
    case (st_r.cfg.dir)
      DIR_DISABLED: dir_ok = 1'b1;
      DIR_FORWARD:  dir_ok = fwd_i;
      DIR_REVERSE:  dir_ok = rev_i;
      default:      dir_ok = 1'b0;
    endcase
    elem = run_i && voted && dir_ok && (st_r.cfg.mode != MODE_DISABLED);
    // Keypad may write only with terminals closed; serial ports ignore them.
    for (int i = 0; i < NUM_IFS; i++)
    begin
      kind[i] = (i == KEYPAD_IDX) ? kp_write_i : wr_en_i[i];
      wr_ok[i] = (pass_zero || st_r.granted[i]) &&
                 ((i != KEYPAD_IDX) || st_r.jump_sync[1]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.jump_sync = {st_r.jump_sync[0], access_jumper_i};
    st_nxt.kp_error = 1'b0;
    st_nxt.rdata = 32'h0000_0000;
    st_nxt.fo.reclose_init = 1'b0;
    st_nxt.fo.event_log = 1'b0;
    fire = 1'b0;
    cand = '0;
    for (int i = 0; i < NUM_IFS; i++)
    begin
      // Idle counters saturate at the limit; the flag clear repeats on every cycle they stay there.
      if (st_r.idle[i] < 43'(IDLE_LIMIT))
        st_nxt.idle[i] = st_r.idle[i] + 43'd1;
      else
        st_nxt.granted[i] = 1'b0;
    end
    // Keypad actions.
    if (kp_valid_i)
    begin
      st_nxt.idle[KEYPAD_IDX] = '0;
      if (kp_enter_pass_i && (kp_data_i == st_r.pass))
        st_nxt.granted[KEYPAD_IDX] = 1'b1;
      if (kp_disable_i)
        st_nxt.granted[KEYPAD_IDX] = 1'b0;
      if (kp_write_i && !wr_ok[KEYPAD_IDX])
        st_nxt.kp_error = 1'b1;
    end
    // Serial ports: access register is the passcode pair; last write is high word.
    for (int i = 1; i < NUM_IFS; i++)
    begin
      if (wr_en_i[i] || rd_en_i[i])
        st_nxt.idle[i] = '0;
      // The low word of an access attempt is held per port, so a refused write still counts.
      if (wr_en_i[i] && addr_i[i] == REG_PASS_LO)
        st_nxt.cand_lo[i] = wdata_i[i];
      if (wr_en_i[i] && addr_i[i] == REG_PASS_HI)
      begin
        cand = {wdata_i[i], st_r.cand_lo[i]};
        st_nxt.granted[i] = (cand == st_r.pass);
      end
    end
    // Setpoint writes from an allowed interface, lowest index wins.
    for (int i = NUM_IFS - 1; i >= 0; i--)
    begin
      logic [3:0]  a;
      logic [31:0] d;
      a = (i == KEYPAD_IDX) ? kp_data_i[35:32] : addr_i[i];
      d = (i == KEYPAD_IDX) ? kp_data_i[31:0] : wdata_i[i];
      if ((i == KEYPAD_IDX ? kp_valid_i : 1'b1) && kind[i] && wr_ok[i])
      begin
        case (a)
          REG_PASS_LO: st_nxt.pass[31:0]  = d;
          REG_PASS_HI:
          begin
            // Only the keypad programs the upper four characters; ports compare there.
            if (i == KEYPAD_IDX)
              st_nxt.pass[63:32] = d;
          end
          REG_FUNC:
          begin
            st_nxt.cfg.mode    = mode_t'(d[F_MODE_LSB +: 3]);
            st_nxt.cfg.aux_sel = d[F_AUX_LSB +: AUX_W];
            st_nxt.cfg.dir     = dir_t'(d[F_DIR_LSB +: 2]);
            st_nxt.cfg.vote    = vote_t'(d[F_VOTE_LSB +: 2]);
            st_nxt.cfg.under   = d[F_UNDER_BIT];
          end
          REG_PICKUP:  st_nxt.cfg.pickup = d[VAL_W-1:0];
          REG_DELAY:   st_nxt.cfg.delay  = d[DLY_W-1:0];
          default:     st_nxt.cfg = st_nxt.cfg;
        endcase
      end
    end
    // Register reads from serial port one.
    if (rd_en_i[1])
    begin
      case (addr_i[1])
        REG_FUNC:   st_nxt.rdata = 32'({st_r.cfg.under, st_r.cfg.vote, st_r.cfg.dir,
                                        st_r.cfg.aux_sel, 1'b0, st_r.cfg.mode});
        REG_PICKUP: st_nxt.rdata = 32'(st_r.cfg.pickup);
        REG_DELAY:  st_nxt.rdata = 32'(st_r.cfg.delay);
        REG_STATUS: st_nxt.rdata = 32'({st_r.latched, st_r.active, st_r.granted});
        default:    st_nxt.rdata = 32'h0000_0000;
      endcase
    end
    // Fixed delay timer from element to feature output.
    case (st_r.tmr)
      TMR_IDLE:
      begin
        st_nxt.tcnt = '0;
        if (elem)
          st_nxt.tmr = TMR_RUN;
      end
      TMR_RUN:
      begin
        if (!elem)
          st_nxt.tmr = TMR_IDLE;
        else if (st_r.tcnt >= st_r.cfg.delay)
          fire = 1'b1;
        else
          st_nxt.tcnt = st_r.tcnt + 24'd1;
      end
      default: st_nxt.tmr = TMR_IDLE;
    endcase
    st_nxt.active = fire;
    if (fire && st_r.cfg.mode == MODE_LATCHED_ALARM)
      st_nxt.latched = 1'b1;
    // Latched alarm holds until the mode is changed away.
    if (st_r.cfg.mode != MODE_LATCHED_ALARM)
      st_nxt.latched = 1'b0;
    begin
      logic on;
      on = fire || st_nxt.latched;
      st_nxt.fo.trip   = on && (st_r.cfg.mode == MODE_TRIP ||
                                st_r.cfg.mode == trip_and_reclose_mode);
      st_nxt.fo.relay1 = st_nxt.fo.trip;
      st_nxt.fo.alarm  = on && (st_r.cfg.mode == MODE_ALARM ||
                                st_r.cfg.mode == MODE_LATCHED_ALARM);
      st_nxt.fo.aux    = (on && st_r.cfg.mode != MODE_DISABLED &&
                          st_r.cfg.mode != MODE_ENABLED) ? st_r.cfg.aux_sel : '0;
      st_nxt.fo.reclose_init = fire && !st_r.active &&
                               st_r.cfg.mode == trip_and_reclose_mode;
      st_nxt.fo.event_log = fire && !st_r.active &&
                            (st_r.cfg.mode == MODE_TRIP || st_r.cfg.mode == MODE_ALARM ||
                             st_r.cfg.mode == trip_and_reclose_mode ||
                             st_r.cfg.mode == MODE_CONTROL);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      st_r      <= '0;
      st_r.pass <= PASS_DEFAULT;
      st_r.tmr  <= TMR_IDLE;
    end
    else
      st_r <= st_nxt;
  end

  assign rdata_o    = st_r.rdata;
  assign kp_error_o = st_r.kp_error;
  assign access_o   = st_r.granted;
  assign feat_o     = st_r.fo;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  sequence s_elem_held;
    elem [*2];
  endsequence

  property p_kp_err;
    @(posedge core_clk_i) disable iff (reset_i)
      kp_valid_i && kp_write_i && !st_r.jump_sync[1] |=> kp_error_o;
  endproperty
  a_kp_err: assert property (p_kp_err) else $error("keypad write not flagged");

  property p_default_pass;
    @(posedge core_clk_i) $fell(reset_i) |-> st_r.pass == PASS_DEFAULT;
  endproperty
  a_default_pass: assert property (p_default_pass) else $error("bad default");

  property p_disable;
    @(posedge core_clk_i) disable iff (reset_i)
      kp_valid_i && kp_disable_i |=> !access_o[KEYPAD_IDX];
  endproperty
  a_disable: assert property (p_disable) else $error("keypad flag kept");

  property p_bad_pass;
    @(posedge core_clk_i) disable iff (reset_i)
      wr_en_i[1] && addr_i[1] == REG_PASS_HI && wdata_i[1] != st_r.pass[63:32]
      |=> !access_o[1];
  endproperty
  a_bad_pass: assert property (p_bad_pass) else $error("port flag kept");

  property p_sep;
    @(posedge core_clk_i) disable iff (reset_i)
      kp_valid_i && !wr_en_i[2] && !rd_en_i[2] && !wr_en_i[1] && st_r.idle[2] < 43'd5
      |=> access_o[2] == $past(access_o[2]);
  endproperty
  a_sep: assert property (p_sep) else $error("flag crosstalk");

  property p_disabled;
    @(posedge core_clk_i) disable iff (reset_i)
      st_r.cfg.mode == MODE_DISABLED [*2] |=> feat_o.aux == '0 && !feat_o.trip;
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled output");

  property p_trip;
    @(posedge core_clk_i) disable iff (reset_i) feat_o.trip |-> feat_o.relay1;
  endproperty
  a_trip: assert property (p_trip) else $error("trip without relay 1");

  property p_delay;
    @(posedge core_clk_i) disable iff (reset_i)
      $rose(st_r.active) |-> $past(st_r.tcnt) == st_r.cfg.delay;
  endproperty
  a_delay: assert property (p_delay) else $error("delay mismatch");

  // Voting is checked against pairwise terms, not against the phase count.
  property p_vote;
    @(posedge core_clk_i) disable iff (reset_i)
      run_i && dir_ok && st_r.cfg.mode != MODE_DISABLED
      |-> elem == ((st_r.cfg.vote == VOTE_ANY_ONE && (|beyond)) ||
                   (st_r.cfg.vote == VOTE_ANY_TWO &&
                    ((beyond[0] && beyond[1]) || (beyond[1] && beyond[2]) ||
                     (beyond[0] && beyond[2]))) ||
                   (st_r.cfg.vote == VOTE_ALL_THREE && (&beyond)));
  endproperty
  a_vote: assert property (p_vote) else $error("vote mismatch");

  property p_tmr_run;
    @(posedge core_clk_i) disable iff (reset_i)
      s_elem_held |-> st_r.tmr == TMR_RUN;
  endproperty
  a_tmr_run: assert property (p_tmr_run) else $error("delay timer not running");

  property p_dir;
    @(posedge core_clk_i) disable iff (reset_i)
      (st_r.cfg.dir == DIR_FORWARD && !fwd_i) || (st_r.cfg.dir == DIR_REVERSE && !rev_i)
      |-> !elem;
  endproperty
  a_dir: assert property (p_dir) else $error("direction not supervised");

  property p_reclose;
    @(posedge core_clk_i) disable iff (reset_i) feat_o.reclose_init |-> feat_o.trip;
  endproperty
  a_reclose: assert property (p_reclose) else $error("reclose without trip");

  property p_alarm;
    @(posedge core_clk_i) disable iff (reset_i)
      feat_o.alarm |-> !feat_o.relay1 && feat_o.aux == $past(st_r.cfg.aux_sel);
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm relays wrong");

  property p_event;
    @(posedge core_clk_i) disable iff (reset_i)
      feat_o.event_log |-> $past(st_r.cfg.mode) != MODE_LATCHED_ALARM &&
                           $past(st_r.cfg.mode) != MODE_ENABLED;
  endproperty
  a_event: assert property (p_event) else $error("event logged in wrong mode");

  property p_kp_ok;
    @(posedge core_clk_i) disable iff (reset_i)
      kp_valid_i && kp_write_i && st_r.jump_sync[1] && pass_zero |=> !kp_error_o;
  endproperty
  a_kp_ok: assert property (p_kp_ok) else $error("keypad write refused");

  // Port writes land with the default passcode whatever the terminals show.
  property p_serial_free;
    @(posedge core_clk_i) disable iff (reset_i)
      wr_en_i[1] && addr_i[1] == REG_PICKUP && pass_zero && !kp_valid_i
      |=> st_r.cfg.pickup == $past(wdata_i[1][VAL_W-1:0]);
  endproperty
  a_serial_free: assert property (p_serial_free) else $error("port write refused");

  property p_idle_clear;
    @(posedge core_clk_i) disable iff (reset_i)
      st_r.idle[1] >= 43'(IDLE_LIMIT) && !(wr_en_i[1] && addr_i[1] == REG_PASS_HI)
      |=> !access_o[1];
  endproperty
  a_idle_clear: assert property (p_idle_clear) else $error("idle flag kept");

  property p_idle_restart;
    @(posedge core_clk_i) disable iff (reset_i)
      wr_en_i[2] || rd_en_i[2] |=> st_r.idle[2] == 43'd0;
  endproperty
  a_idle_restart: assert property (p_idle_restart) else $error("idle timer kept");
endmodule : setpoint_access
`default_nettype wire

// ===== dv/host_model.sv
// Keypad and serial master model that drives the request side of the access block.
`default_nettype none
module host_model
  import setpoint_access_pkg::*;
(
  input  wire logic          core_clk_i,
  output logic               kp_valid_o,
  output logic               kp_write_o,
  output logic               kp_enter_pass_o,
  output logic               kp_disable_o,
  output logic [PASS_W-1:0]  kp_data_o,
  output logic [NUM_IFS-1:0] wr_en_o,
  output logic [NUM_IFS-1:0] rd_en_o,
  output logic [3:0]         addr_o [NUM_IFS],
  output logic [31:0]        wdata_o [NUM_IFS]
);
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////////////////////////
  // Everything idles low at time zero so reset sees no request.
  initial
  begin
    {kp_valid_o, kp_write_o, kp_enter_pass_o, kp_disable_o} = 4'h0;
    kp_data_o = '0;
    wr_en_o = '0;
    rd_en_o = '0;
    addr_o = '{default: 4'h0};
    wdata_o = '{default: 32'h0};
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One serial cycle; released lines show the inverse so stale data never looks valid.
  task automatic ser(input int p, input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    wr_en_o[p] <= wr;
    rd_en_o[p] <= !wr;
    addr_o[p]  <= a;
    wdata_o[p] <= d;
    @(posedge core_clk_i);
    wr_en_o[p] <= 1'b0;
    rd_en_o[p] <= 1'b0;
    addr_o[p]  <= ~a;
    wdata_o[p] <= ~d;
  endtask : ser

  // One keypad action; k is {write, enter passcode, disable}.
  task automatic kp(input logic [2:0] k, input logic [PASS_W-1:0] d);
    @(posedge core_clk_i);
    kp_valid_o <= 1'b1;
    {kp_write_o, kp_enter_pass_o, kp_disable_o} <= k;
    kp_data_o <= d;
    @(posedge core_clk_i);
    kp_valid_o <= 1'b0;
    {kp_write_o, kp_enter_pass_o, kp_disable_o} <= 3'h0;
    kp_data_o <= ~d;
  endtask : kp
endmodule : host_model
`default_nettype wire

// ===== dv/tb_top.sv
// Self-checking testbench for the setpoint access and feature output block.
`default_nettype none
module tb_top;
  import setpoint_access_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam longint IDLE = 60;
  localparam int     DLY  = 10;
  typedef struct {int k; logic [31:0] v;} note_t;
  logic core_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic jumper = 1'b0, run = 1'b1, fwd = 1'b0, rev = 1'b0;
  logic [VAL_W-1:0] meas [3] = '{default: 16'h0000};
  logic kv, kw, ke, kd;
  logic [PASS_W-1:0] kdat;
  logic [NUM_IFS-1:0] wr, rd;
  logic [3:0] addr [NUM_IFS];
  logic [31:0] wdat [NUM_IFS];
  logic [31:0] rdata, got;
  logic kp_err;
  logic [2:0] acc;
  feat_out_t feat;
  note_t exp_q [$];
  note_t e;
  int mismatches = 0, n_tests = 0, cyc = 0, ev_cnt = 0, rc_cnt = 0, ev_b = 0, rc_b = 0;
  // Control-mode cases, fields {dir, vote, under, phases, fwd, rev, run, output}.
  logic [11:0] vt [12] = '{12'h013, 12'h122, 12'h163, 12'h232, 12'h277, 12'h44B,
                           12'h446, 12'h847, 12'h84A, 12'h070, 12'h093, 12'h082};

  always #12.5 core_clk_i = ~core_clk_i;

  host_model host (.core_clk_i(core_clk_i), .kp_valid_o(kv), .kp_write_o(kw),
    .kp_enter_pass_o(ke), .kp_disable_o(kd), .kp_data_o(kdat), .wr_en_o(wr),
    .rd_en_o(rd), .addr_o(addr), .wdata_o(wdat));

  setpoint_access #(.IDLE_LIMIT(IDLE)) dut (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .access_jumper_i(jumper), .kp_valid_i(kv), .kp_write_i(kw), .kp_enter_pass_i(ke),
    .kp_disable_i(kd), .kp_data_i(kdat), .wr_en_i(wr), .rd_en_i(rd), .addr_i(addr),
    .wdata_i(wdat), .run_i(run), .fwd_i(fwd), .rev_i(rev), .meas_i(meas),
    .rdata_o(rdata), .kp_error_o(kp_err), .access_o(acc), .feat_o(feat));

  ////////////////////////////////////////////////////////////////////////////////
  // Pulses are counted here so a one-cycle event is never missed between checks.
  always @(posedge core_clk_i)
  begin
    cyc++;
    if (feat.event_log === 1'b1) ev_cnt++;
    if (feat.reclose_init === 1'b1) rc_cnt++;
    if (cyc == 5000)
    begin
      mismatches++;
      results();
    end
  end

  // The watcher takes the oldest note when an answer stands and compares it.
  always @(negedge core_clk_i)
    if (exp_q.size() != 0)
    begin
      e = exp_q.pop_front();
      case (e.k)
        0: got = {28'h0, kp_err, acc};
        1: got = rdata;
        2: got = {24'h0, feat.trip, feat.alarm, feat.relay1, feat.aux};
        4: got = 32'((ev_cnt - ev_b) * 16 + (rc_cnt - rc_b));
        5: got = {31'h0, kp_err};
        default: got = {29'h0, acc};
      endcase
      n_tests++;
      if (got !== e.v)
      begin
        mismatches++;
        $display("wrong value at %0t: got %h expected %h", $time, got, e.v);
      end
    end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic note(input int k, input logic [31:0] v);
    exp_q.push_back('{k, v});
  endtask : note

  task automatic sw(input int p, input logic [3:0] a, input logic [31:0] d);
    host.ser(p, 1'b1, a, d);
  endtask : sw

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] v);
    host.ser(1, 1'b0, a, 32'h0);
    note(1, v);
  endtask : rd_chk

  // Phases in ph go beyond pickup 0x0100; under flips which side is beyond.
  task automatic drive(input logic [2:0] ph, input logic u);
    for (int i = 0; i < 3; i++)
      meas[i] <= (ph[i] ^ u) ? 16'h0101 + 16'($urandom % 1000) : 16'($urandom % 256);
  endtask : drive

  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : results

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: features first while the passcode is still the default.
  initial
  begin
    void'($urandom(32'h34CD164E));
    repeat (10) @(posedge core_clk_i);
    reset_i <= 1'b0;
    @(posedge core_clk_i);
    note(0, 32'h0);
    host.kp(3'h2, 64'h30);
    note(0, 32'h1);
    sw(1, REG_PICKUP, 32'h100);
    sw(1, REG_DELAY, 32'(DLY));
    for (int m = 0; m < 7; m++)
    begin
      sw(1, REG_FUNC, {18'h0, 1'b0, 2'h0, 2'h0, 5'h15, 1'b0, 3'(m)});
      ev_b = ev_cnt;
      rc_b = rc_cnt;
      drive(3'h7, 1'b0);
      repeat (DLY - 1) @(posedge core_clk_i);
      note(2, 32'h0);
      repeat (6) @(posedge core_clk_i);
      note(2, (m == 2 || m == 3) ? 32'hB5 : (m > 3 && m < 6) ? 32'h55 :
              m == 6 ? 32'h15 : 32'h0);
      drive(3'h0, 1'b0);
      repeat (DLY + 5) @(posedge core_clk_i);
      note(4, ((m == 2 || m == 3 || m == 4 || m == 6) ? 32'h10 : 0) + (m == 3));
    end
    $display("test function modes done");
    foreach (vt[i])
    begin
      sw(1, REG_FUNC, {18'h0, vt[i][7], vt[i][9:8], vt[i][11:10], 5'h1F, 4'h6});
      {fwd, rev, run} <= vt[i][3:1];
      drive(vt[i][6:4], vt[i][7]);
      repeat (DLY + 5) @(posedge core_clk_i);
      note(2, vt[i][0] ? 32'h1F : 32'h0);
      drive(3'h0, vt[i][7]);
      repeat (DLY + 5) @(posedge core_clk_i);
    end
    $display("test supervision and voting done");
    sw(1, REG_PICKUP, 32'h111);
    rd_chk(REG_PICKUP, 32'h111);
    host.kp(3'h4, {28'h0, REG_PICKUP, 32'h222});
    note(5, 32'h1);
    rd_chk(REG_PICKUP, 32'h111);
    jumper <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    host.kp(3'h4, {28'h0, REG_PICKUP, 32'h333});
    note(5, 32'h0);
    rd_chk(REG_PICKUP, 32'h333);
    host.kp(3'h4, {28'h0, REG_PASS_LO, 32'h1234});
    host.kp(3'h2, 64'h1234);
    note(0, 32'h1);
    host.kp(3'h1, 64'h0);
    note(0, 32'h0);
    sw(2, REG_PICKUP, 32'h444);
    host.kp(3'h4, {28'h0, REG_PICKUP, 32'h555});
    rd_chk(REG_PICKUP, 32'h333);
    sw(1, REG_PASS_LO, 32'h1234);
    sw(1, REG_PASS_HI, 32'h0);
    note(0, 32'h2);
    sw(1, REG_PICKUP, 32'h666);
    sw(2, REG_PICKUP, 32'h777);
    rd_chk(REG_PICKUP, 32'h666);
    host.kp(3'h2, 64'h1235);
    note(0, 32'h2);
    host.kp(3'h2, 64'h1234);
    note(0, 32'h3);
    host.kp(3'h1, 64'h0);
    note(0, 32'h2);
    sw(1, REG_PASS_HI, 32'h1);
    note(0, 32'h0);
    sw(2, REG_PASS_LO, 32'h1234);
    sw(2, REG_PASS_HI, 32'h0);
    repeat (40) @(posedge core_clk_i);
    host.ser(2, 1'b0, REG_STATUS, 32'h0);
    repeat (40) @(posedge core_clk_i);
    note(6, 32'h4);
    repeat (IDLE + 10) @(posedge core_clk_i);
    note(6, 32'h0);
    @(posedge core_clk_i);
    $display("test setpoint access done");
    results();
  end
endmodule : tb_top
`default_nettype wire
